//--- hw/nfc_pkg.sv
// shared constants and types for the non-critical fault collector
package nfc_pkg;

  // ----------------------------------------------------------------
  // register byte offsets on the ahb-lite port
  // ----------------------------------------------------------------
  localparam logic [7:0] OFF_STATUS = 8'h00;
  localparam logic [7:0] OFF_ENABLE = 8'h04;
  localparam logic [7:0] OFF_REACT = 8'h08;
  localparam logic [7:0] OFF_TOE = 8'h0c;
  localparam logic [7:0] OFF_TIMEOUT = 8'h10;
  localparam logic [7:0] OFF_CTRL = 8'h14;
  localparam logic [7:0] OFF_STATE = 8'h18;

  // ----------------------------------------------------------------
  // non-critical input positions
  // ----------------------------------------------------------------
  localparam int IN_CORE0_PREWARN = 0;
  localparam int IN_CORE1_PREWARN = 1;
  localparam int IN_PLL_A_UNLOCK = 2;
  localparam int IN_PLL_B_UNLOCK = 3;
  localparam int IN_OSC_LOSS = 4;
  localparam int IN_SYSCLK_RANGE = 5;
  localparam int IN_MOTOR_CLK_RANGE = 6;
  localparam int IN_NET_CLK_RANGE = 7;
  localparam int IN_ECC_NOTE_A = 8;
  localparam int IN_ECC_NOTE_B = 9;
  localparam int IN_CONV_A = 10;
  localparam int IN_CONV_B = 11;
  localparam int IN_SELFTEST = 12;
  localparam int IN_NET_RAM_CORR = 19;
  localparam int IN_NET_RAM_UNCORR = 20;
  localparam int IN_SW_RESET = 21;
  localparam int IN_CONV_C = 25;
  localparam int IN_CONV_D = 26;

  // implemented inputs and the ones classed for a long functional reset
  localparam logic [31:0] IMPL_MASK = 32'h0638_1fff;
  localparam logic [31:0] LONG_MASK = 32'h0000_00ff;

  // ----------------------------------------------------------------
  // reset values and field positions
  // ----------------------------------------------------------------
  localparam logic [31:0] ENABLE_RST = 32'h0638_1fff;
  localparam logic [31:0] REACT_RST = 32'h0000_0000;
  localparam logic [31:0] TOE_RST = 32'h0000_0000;
  localparam logic [31:0] TIMEOUT_RST = 32'h0000_1000;
  localparam int CTRL_PAD_DIS = 0;
  localparam int CTRL_FAULT_CLR = 1;
  localparam int STATE_LONG_REQ = 2;
  localparam int STATE_SAFE = 3;
  localparam int STATE_REPORT = 4;
  localparam int STATE_CRIT = 5;

  // error pin patterns: healthy and failure are complementary pairs
  localparam logic [1:0] ERR_OK = 2'b01;
  localparam logic [1:0] ERR_FAULT = 2'b10;

  typedef enum logic [1:0] {
    ST_NORMAL = 2'b00,
    ST_ALARM = 2'b01,
    ST_FAULT = 2'b10
  } nfc_state_e;

  typedef logic [31:0] nfc_word_t;

endpackage

//--- hw/nfc_sync.sv
// two-flop synchroniser for a vector of asynchronous levels
`timescale 1ns/1ps
module nfc_sync #(
  parameter int WIDTH = 18
) (
  input logic hclk,
  input logic hresetn,
  input logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] dout
);

  logic [WIDTH-1:0] stage1;

  if (WIDTH < 1) begin : g_chk
    $error("nfc_sync width must be at least one");
  end

  // ----------------------------------------------------------------
  // synchroniser chain
  // ----------------------------------------------------------------
  // stage1 feeds only stage two, so no logic sees a metastable value
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      stage1 <= '0;
      dout <= '0;
    end else begin
      stage1 <= din;
      dout <= stage1;
    end
  end

endmodule

//--- hw/nfc_error_pins.sv
// driver for the pair of external error pins
`timescale 1ns/1ps
module nfc_error_pins (
  input logic hclk,
  input logic hresetn,
  input logic report,
  output logic [1:0] pin_out,
  output logic [1:0] pin_oe
);

  // ----------------------------------------------------------------
  // pin drive
  // ----------------------------------------------------------------
  // enables clear asynchronously so the pins float at once in reset
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pin_oe <= 2'b00; // RQ12
    end else begin
      pin_oe <= 2'b11; // RQ11
    end
  end

  // the level pattern itself; no enable input exists to silence it
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pin_out <= nfc_pkg::ERR_OK;
    end else if (report) begin
      pin_out <= nfc_pkg::ERR_FAULT; // RQ16
    end else begin
      pin_out <= nfc_pkg::ERR_OK;
    end
  end

endmodule

//--- hw/nfc_collector.sv
// non-critical fault collector with ahb-lite registers and error pins
// Function
// RQ1: core watchdog prewarnings drive inputs 0 and 1, long reset class.
// RQ2: pll loss of lock drives inputs 2 and 3, long reset class.
// RQ3: crystal oscillator loss raises input 4, long reset class.
// RQ4: system clock out of range raises input 5, long reset class.
// RQ5: motor and network clocks out of range raise inputs 6 and 7, long.
// RQ6: single-bit ecc notes drive inputs 8 and 9, no reset.
// RQ7: converter self-test faults drive inputs 10, 11, 25, 26, no reset.
// RQ8: self-test unit failure drives input 12, no reset.
// RQ9: network ram ecc corrected input 19, uncorrectable input 20, no reset.
// RQ10: software reset request drives input 21, no reset class.
// RQ11: two external error pins report critical errors in safe mode.
// RQ12: both error pins float while the device is in reset.
// RQ13: external monitor watches both pins and enforces safe state in time.
// RQ14: after configuration faults are collected and reacted on autonomously.
// RQ15: registers select input enables, fault-state reactions and timeouts.
// RQ16: external error reaction is always on and cannot be disabled.
// RQ17: with pad disable set, system pads float on entering safe mode.
// RQ18: external system stays safe alone and may reset the device.
// RQ19: reserved inputs are tied inactive and never set status.
// RQ20: each input latches a sticky flag until software clears it.
//
// Local design decisions: the address map and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
module nfc_collector (
  input logic hclk,
  input logic hresetn,
  input logic hsel,
  input logic [31:0] haddr,
  input logic [1:0] htrans,
  input logic hwrite,
  input logic [2:0] hsize,
  input logic hready,
  input logic [31:0] hwdata,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input logic core0_prewarn_status,
  input logic core1_prewarn_status,
  input logic freq_mod_pll_a_unlock,
  input logic freq_mod_pll_b_unlock,
  input logic clock_monitor_a_osc_loss,
  input logic clock_monitor_a_sysclk_range,
  input logic clock_monitor_b_motor_range,
  input logic clock_monitor_c_network_range,
  input logic ecc_corrected_note_a,
  input logic ecc_corrected_note_b,
  input logic converter_selftest_fault_a,
  input logic converter_selftest_fault_b,
  input logic converter_selftest_fault_c,
  input logic converter_selftest_fault_d,
  input logic selftest_unit_fault,
  input logic network_ram_corrected,
  input logic network_ram_uncorrectable,
  input logic mode_entry_reset_req,
  input logic critical_fault,
  input logic safe_mode,
  output logic [1:0] external_error_outputs,
  output logic [1:0] external_error_oe,
  output logic long_reset_req,
  output logic fault_state_active,
  output logic safe_pad_hiz
);

  localparam int NSRC = 18;

  logic [NSRC-1:0] src_raw;
  logic [NSRC-1:0] src_sync;
  nfc_pkg::nfc_word_t fault_raw;
  nfc_pkg::nfc_word_t status;
  nfc_pkg::nfc_word_t enable;
  nfc_pkg::nfc_word_t react;
  nfc_pkg::nfc_word_t toe;
  nfc_pkg::nfc_word_t timeout;
  nfc_pkg::nfc_word_t tmo_cnt;
  nfc_pkg::nfc_word_t w1c_mask;
  nfc_pkg::nfc_word_t rd_word;
  nfc_pkg::nfc_state_e state;
  nfc_pkg::nfc_state_e next_state;
  logic pad_dis;
  logic wr_pend;
  logic [7:0] wr_addr;
  logic accept;
  logic immediate;
  logic alarm_pend;
  logic long_pend;
  logic fault_clr;
  logic err_report;

  // decode of a write data phase against one register offset
  function automatic logic wr_hit(input logic pend, input logic [7:0] a,
                                  input logic [7:0] off);
    return pend && (a == off);
  endfunction

  // ----------------------------------------------------------------
  // fault source capture
  // ----------------------------------------------------------------
  // sources live in foreign clock domains, so each is synchronised
  assign src_raw = {mode_entry_reset_req, network_ram_uncorrectable,
                    network_ram_corrected, converter_selftest_fault_d,
                    converter_selftest_fault_c, selftest_unit_fault,
                    converter_selftest_fault_b, converter_selftest_fault_a,
                    ecc_corrected_note_b, ecc_corrected_note_a,
                    clock_monitor_c_network_range, clock_monitor_b_motor_range,
                    clock_monitor_a_sysclk_range, clock_monitor_a_osc_loss,
                    freq_mod_pll_b_unlock, freq_mod_pll_a_unlock,
                    core1_prewarn_status, core0_prewarn_status};

  nfc_sync #(.WIDTH(NSRC)) u_sync (
    .hclk(hclk),
    .hresetn(hresetn),
    .din(src_raw),
    .dout(src_sync)
  );

  // map synchronised sources onto the indexed inputs
  always_comb begin
    fault_raw = '0; // RQ19
    fault_raw[nfc_pkg::IN_CORE0_PREWARN] = src_sync[0]; // RQ1
    fault_raw[nfc_pkg::IN_CORE1_PREWARN] = src_sync[1]; // RQ1
    fault_raw[nfc_pkg::IN_PLL_A_UNLOCK] = src_sync[2]; // RQ2
    fault_raw[nfc_pkg::IN_PLL_B_UNLOCK] = src_sync[3]; // RQ2
    fault_raw[nfc_pkg::IN_OSC_LOSS] = src_sync[4]; // RQ3
    fault_raw[nfc_pkg::IN_SYSCLK_RANGE] = src_sync[5]; // RQ4
    fault_raw[nfc_pkg::IN_MOTOR_CLK_RANGE] = src_sync[6]; // RQ5
    fault_raw[nfc_pkg::IN_NET_CLK_RANGE] = src_sync[7]; // RQ5
    fault_raw[nfc_pkg::IN_ECC_NOTE_A] = src_sync[8]; // RQ6
    fault_raw[nfc_pkg::IN_ECC_NOTE_B] = src_sync[9]; // RQ6
    fault_raw[nfc_pkg::IN_CONV_A] = src_sync[10]; // RQ7
    fault_raw[nfc_pkg::IN_CONV_B] = src_sync[11]; // RQ7
    fault_raw[nfc_pkg::IN_SELFTEST] = src_sync[12]; // RQ8
    fault_raw[nfc_pkg::IN_CONV_C] = src_sync[13]; // RQ7
    fault_raw[nfc_pkg::IN_CONV_D] = src_sync[14]; // RQ7
    fault_raw[nfc_pkg::IN_NET_RAM_CORR] = src_sync[15]; // RQ9
    fault_raw[nfc_pkg::IN_NET_RAM_UNCORR] = src_sync[16]; // RQ9
    fault_raw[nfc_pkg::IN_SW_RESET] = src_sync[17]; // RQ10
  end

  // ----------------------------------------------------------------
  // ahb-lite slave
  // ----------------------------------------------------------------
  // zero wait states: every transfer completes in its first data cycle
  assign accept = hsel && hready && htrans[1];

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend <= 1'b0;
      wr_addr <= 8'h00;
    end else begin
      wr_pend <= accept && hwrite;
      wr_addr <= haddr[7:0];
    end
  end

  // responses are fixed; hsize is not checked, all accesses act as words
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b0;
      hresp <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  // read mux; upper address bits are not decoded, so the map aliases
  always_comb begin
    rd_word = '0;
    unique case (haddr[7:0])
      nfc_pkg::OFF_STATUS: rd_word = status;
      nfc_pkg::OFF_ENABLE: rd_word = enable;
      nfc_pkg::OFF_REACT: rd_word = react;
      nfc_pkg::OFF_TOE: rd_word = toe;
      nfc_pkg::OFF_TIMEOUT: rd_word = timeout;
      nfc_pkg::OFF_CTRL: rd_word[nfc_pkg::CTRL_PAD_DIS] = pad_dis;
      nfc_pkg::OFF_STATE: begin
        rd_word[1:0] = state;
        rd_word[nfc_pkg::STATE_LONG_REQ] = long_reset_req;
        rd_word[nfc_pkg::STATE_SAFE] = safe_mode;
        rd_word[nfc_pkg::STATE_REPORT] = err_report;
        rd_word[nfc_pkg::STATE_CRIT] = critical_fault;
      end
      default: rd_word = '0;
    endcase
  end

  // read data is captured at the address phase and stands in the data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= '0;
    end else if (accept && !hwrite) begin
      hrdata <= rd_word;
    end
  end

  // ----------------------------------------------------------------
  // configuration registers
  // ----------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      enable <= nfc_pkg::ENABLE_RST;
      react <= nfc_pkg::REACT_RST;
      toe <= nfc_pkg::TOE_RST;
      timeout <= nfc_pkg::TIMEOUT_RST;
      pad_dis <= 1'b0;
    end else begin
      if (wr_hit(wr_pend, wr_addr, nfc_pkg::OFF_ENABLE)) begin
        enable <= hwdata & nfc_pkg::IMPL_MASK; // RQ15
      end
      if (wr_hit(wr_pend, wr_addr, nfc_pkg::OFF_REACT)) begin
        react <= hwdata & nfc_pkg::IMPL_MASK; // RQ15
      end
      if (wr_hit(wr_pend, wr_addr, nfc_pkg::OFF_TOE)) begin
        toe <= hwdata & nfc_pkg::IMPL_MASK; // RQ15
      end
      if (wr_hit(wr_pend, wr_addr, nfc_pkg::OFF_TIMEOUT)) begin
        timeout <= hwdata;
      end
      if (wr_hit(wr_pend, wr_addr, nfc_pkg::OFF_CTRL)) begin
        pad_dis <= hwdata[nfc_pkg::CTRL_PAD_DIS];
      end
    end
  end

  // the fault clear bit is a write-only strobe and is never stored
  assign fault_clr = wr_hit(wr_pend, wr_addr, nfc_pkg::OFF_CTRL) &&
                     hwdata[nfc_pkg::CTRL_FAULT_CLR];

  // ----------------------------------------------------------------
  // sticky status
  // ----------------------------------------------------------------
  assign w1c_mask = wr_hit(wr_pend, wr_addr, nfc_pkg::OFF_STATUS) ? hwdata : '0;

  // a fault present during a clear survives it, so no event is lost
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      status <= '0;
    end else begin
      status <= (fault_raw & nfc_pkg::IMPL_MASK) | (status & ~w1c_mask); // RQ20
    end
  end

  // ----------------------------------------------------------------
  // fault reaction state machine
  // ----------------------------------------------------------------
  assign immediate = |(status & enable & react);
  assign alarm_pend = |(status & enable & toe);
  assign long_pend = |(status & enable & nfc_pkg::LONG_MASK);

  // runs without software once configured; leaving fault, or leaving alarm back to normal, needs a write
  always_comb begin
    next_state = state;
    unique case (state)
      nfc_pkg::ST_NORMAL: begin
        if (immediate) begin
          next_state = nfc_pkg::ST_FAULT; // RQ14
        end else if (alarm_pend) begin
          next_state = nfc_pkg::ST_ALARM; // RQ15
        end
      end
      nfc_pkg::ST_ALARM: begin
        if (immediate || (tmo_cnt >= timeout)) begin
          next_state = nfc_pkg::ST_FAULT; // RQ14
        end else if (!alarm_pend) begin
          next_state = nfc_pkg::ST_NORMAL;
        end
      end
      nfc_pkg::ST_FAULT: begin
        if (fault_clr && !immediate && !alarm_pend) begin
          next_state = nfc_pkg::ST_NORMAL;
        end
      end
      default: next_state = nfc_pkg::ST_NORMAL;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state <= nfc_pkg::ST_NORMAL;
    end else begin
      state <= next_state;
    end
  end

  // timeout counter restarts on every entry to the alarm state
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tmo_cnt <= '0;
    end else if (state == nfc_pkg::ST_ALARM) begin
      tmo_cnt <= tmo_cnt + 32'h0000_0001;
    end else begin
      tmo_cnt <= '0;
    end
  end

  // ----------------------------------------------------------------
  // reactions towards reset, pads and the error pins
  // ----------------------------------------------------------------
  // only the clock and watchdog inputs carry a long reset class
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      long_reset_req <= 1'b0;
      fault_state_active <= 1'b0;
      safe_pad_hiz <= 1'b0;
    end else begin
      long_reset_req <= (state == nfc_pkg::ST_FAULT) && long_pend; // RQ1
      fault_state_active <= (state == nfc_pkg::ST_FAULT);
      safe_pad_hiz <= safe_mode && pad_dis; // RQ17
    end
  end

  // no register term appears here: the external reaction cannot be masked
  assign err_report = (state == nfc_pkg::ST_FAULT) || (safe_mode && critical_fault); // RQ16

  nfc_error_pins u_pins (
    .hclk(hclk),
    .hresetn(hresetn),
    .report(err_report),
    .pin_out(external_error_outputs),
    .pin_oe(external_error_oe)
  );

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  sequence clr_strobe_s;
    fault_clr && !immediate && !alarm_pend;
  endsequence

  sequence in_fault_s;
    state == nfc_pkg::ST_FAULT;
  endsequence

  flag_hold_a: assert property (@(posedge hclk) disable iff (!hresetn) // RQ20
    1 |=> ((($past(status) & ~$past(w1c_mask)) & ~status) == 32'h0))
    else $error("sticky flag dropped without a clear");

  set_wins_a: assert property (@(posedge hclk) disable iff (!hresetn) // RQ20
    1 |=> (($past(fault_raw) & nfc_pkg::IMPL_MASK & ~status) == 32'h0))
    else $error("fault seen but flag not set");

  reserved_idle_a: assert property (@(posedge hclk) disable iff (!hresetn) // RQ19
    (status & ~nfc_pkg::IMPL_MASK) == 32'h0)
    else $error("reserved input flag set");

  immed_fault_a: assert property (@(posedge hclk) disable iff (!hresetn) // RQ15
    immediate |=> in_fault_s)
    else $error("enabled reaction did not enter fault state");

  timeout_fault_a: assert property (@(posedge hclk) disable iff (!hresetn) // RQ14
    (state == nfc_pkg::ST_ALARM && tmo_cnt >= timeout) |=> in_fault_s)
    else $error("alarm timeout did not enter fault state");

  fault_exit_a: assert property (@(posedge hclk) disable iff (!hresetn) // RQ14
    in_fault_s ##0 clr_strobe_s |=> state == nfc_pkg::ST_NORMAL)
    else $error("fault clear did not return to normal");

  long_class_a: assert property (@(posedge hclk) disable iff (!hresetn) // RQ1
    (in_fault_s and (long_pend == 1'b1)) |=> long_reset_req ##1
      (long_reset_req == $past(state == nfc_pkg::ST_FAULT && long_pend)))
    else $error("long reset request does not follow fault class");

  pin_report_a: assert property (@(posedge hclk) disable iff (!hresetn) // RQ11
    err_report |-> ##[1:2] external_error_outputs == nfc_pkg::ERR_FAULT)
    else $error("error pins did not show the failure pattern");

  pin_drive_a: assert property (@(posedge hclk) disable iff (!hresetn) // RQ16
    hresetn |=> external_error_oe == 2'b11)
    else $error("error pins not driven after reset");

  pad_float_a: assert property (@(posedge hclk) disable iff (!hresetn) // RQ17
    (safe_mode && pad_dis) |=> safe_pad_hiz)
    else $error("pads not released in safe mode");

endmodule

//--- verif/nfc_safety_monitor.sv
// behavioural model of the external safety monitor on the error pins
`timescale 1ns/1ps
module nfc_safety_monitor (
  input wire logic hclk,
  input wire logic monitor_rst_n,
  input wire logic [1:0] pin_out,
  input wire logic [1:0] pin_oe,
  output logic safe_state
);
  // ----------------------------------------
  // pin level and safe-state latch
  // ----------------------------------------
  logic [1:0] pin_level;
  // a released pin reads as z, so a stale driven value can never look like a failure
  assign pin_level = {pin_oe[1] ? pin_out[1] : 1'bz, pin_oe[0] ? pin_out[0] : 1'bz};
  // goes safe one edge after a failure pattern, then holds without the device's help
  always_ff @(posedge hclk or negedge monitor_rst_n) begin
    if (!monitor_rst_n) begin
      safe_state <= 1'b0;
    end else if (pin_level === nfc_pkg::ERR_FAULT) begin
      safe_state <= 1'b1;
    end
  end
endmodule

//--- verif/tb_top.sv
// self-checking testbench for the non-critical fault collector
`timescale 1ns/1ps
module tb_top;
  logic hclk, hresetn, hsel, hwrite, mon_rst_n, crit, safe;
  logic [31:0] haddr, hwdata, hrdata, src, rd;
  logic [1:0] htrans, err_out, err_oe;
  logic [2:0] hsize;
  logic hreadyout, hresp, long_req, fault_act, pad_hiz, safe_state;
  int bad_count, n_checks, cycles;
  // ----------------------------------------
  // clock, instances and hang guard
  // ----------------------------------------
  initial begin
    hclk = 1'b0;
    forever #2 hclk = ~hclk;
  end
  nfc_collector nfc_collector_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hreadyout),
    .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .core0_prewarn_status(src[0]), .core1_prewarn_status(src[1]),
    .freq_mod_pll_a_unlock(src[2]), .freq_mod_pll_b_unlock(src[3]),
    .clock_monitor_a_osc_loss(src[4]), .clock_monitor_a_sysclk_range(src[5]),
    .clock_monitor_b_motor_range(src[6]), .clock_monitor_c_network_range(src[7]),
    .ecc_corrected_note_a(src[8]), .ecc_corrected_note_b(src[9]),
    .converter_selftest_fault_a(src[10]), .converter_selftest_fault_b(src[11]),
    .converter_selftest_fault_c(src[25]), .converter_selftest_fault_d(src[26]),
    .selftest_unit_fault(src[12]), .network_ram_corrected(src[19]),
    .network_ram_uncorrectable(src[20]), .mode_entry_reset_req(src[21]),
    .critical_fault(crit), .safe_mode(safe), .external_error_outputs(err_out),
    .external_error_oe(err_oe), .long_reset_req(long_req),
    .fault_state_active(fault_act), .safe_pad_hiz(pad_hiz));
  nfc_safety_monitor nfc_safety_monitor_inst (.hclk(hclk), .monitor_rst_n(mon_rst_n),
    .pin_out(err_out), .pin_oe(err_oe), .safe_state(safe_state));
  // the whole run needs well under a thousand cycles; far beyond that means a hang
  always @(posedge hclk) begin
    cycles++;
    if (cycles == 20000) begin
      bad_count++;
      test_done();
    end
  end
  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic test_done();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wait_n(input int n);
    repeat (n) @(posedge hclk);
  endtask
  // one single ahb-lite transfer; waits for hready at both phases, no cycle count assumed
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] wd);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {24'h00_0000, a};
    htrans <= 2'b10;
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask
  task automatic rdchk(input string what, input logic [7:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h0000_0000);
    chk(what, exp, rd);
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_regs();
    rdchk("enable reset", nfc_pkg::OFF_ENABLE, nfc_pkg::ENABLE_RST);
    rdchk("timeout reset", nfc_pkg::OFF_TIMEOUT, nfc_pkg::TIMEOUT_RST);
    wr(nfc_pkg::OFF_STATUS, 32'hffff_ffff);
    rdchk("status no set by write", nfc_pkg::OFF_STATUS, 32'h0000_0000);
    wr(nfc_pkg::OFF_ENABLE, 32'hfff0_0000);
    rdchk("enable masked", nfc_pkg::OFF_ENABLE, nfc_pkg::IMPL_MASK & 32'hfff0_0000);
    wr(nfc_pkg::OFF_ENABLE, 32'hffff_ffff);
    rdchk("unmapped", 8'h40, 32'h0000_0000);
    chk("hresp", 32'(hresp), 32'h0000_0000);
    $display("test regs done");
  endtask
  // every source sets only its own flag, which stays after the source drops
  task automatic t_map();
    for (int p = 0; p < 32; p++) begin
      if (nfc_pkg::IMPL_MASK[p]) begin
        src[p] <= 1'b1;
        wait_n(5);
        src[p] <= 1'b0;
        wait_n(5);
        rdchk("status map", nfc_pkg::OFF_STATUS, 32'h1 << p);
        chk("no reset without react", 32'(long_req), 32'h0000_0000);
        wr(nfc_pkg::OFF_STATUS, 32'h1 << p);
        rdchk("status clear", nfc_pkg::OFF_STATUS, 32'h0000_0000);
      end
    end
    $display("test map done");
  endtask
  // react path to fault state, pins, reset class and recovery
  task automatic t_react(input int p);
    wr(nfc_pkg::OFF_REACT, 32'h1 << p);
    src[p] <= 1'b1;
    wait_n(6);
    rdchk("state fault", nfc_pkg::OFF_STATE, 32'h0000_0000 | nfc_pkg::ST_FAULT
      | (32'(nfc_pkg::LONG_MASK[p]) << nfc_pkg::STATE_LONG_REQ) | 32'h10);
    chk("pins fault", 32'(err_out), 32'(nfc_pkg::ERR_FAULT));
    chk("pins driven", 32'(err_oe), 32'h0000_0003);
    chk("long class", 32'(long_req), 32'(nfc_pkg::LONG_MASK[p]));
    chk("fault active", 32'(fault_act), 32'h0000_0001);
    chk("monitor safe", 32'(safe_state), 32'h0000_0001);
    src[p] <= 1'b0;
    wait_n(4);
    wr(nfc_pkg::OFF_STATUS, 32'h1 << p);
    wr(nfc_pkg::OFF_CTRL, 32'h0000_0002);
    wait_n(3);
    rdchk("state normal", nfc_pkg::OFF_STATE, 32'h0000_0000);
    chk("pins ok", 32'(err_out), 32'(nfc_pkg::ERR_OK));
    chk("monitor holds", 32'(safe_state), 32'h0000_0001);
    wr(nfc_pkg::OFF_REACT, 32'h0000_0000);
    mon_rst_n <= 1'b0;
    wait_n(1);
    mon_rst_n <= 1'b1;
    $display("test react %0d done", p);
  endtask
  // alarm with timeout escalates to fault after the programmed count
  task automatic t_timeout();
    wr(nfc_pkg::OFF_TIMEOUT, 32'h0000_0014);
    rdchk("timeout rw", nfc_pkg::OFF_TIMEOUT, 32'h0000_0014);
    wr(nfc_pkg::OFF_TOE, 32'h0000_0200);
    src[9] <= 1'b1;
    wait_n(6);
    rdchk("state alarm", nfc_pkg::OFF_STATE, 32'(nfc_pkg::ST_ALARM));
    chk("no early fault", 32'(fault_act), 32'h0000_0000);
    wait_n(25);
    chk("alarm escalates", 32'(fault_act), 32'h0000_0001);
    src[9] <= 1'b0;
    wait_n(4);
    wr(nfc_pkg::OFF_TOE, 32'h0000_0000);
    wr(nfc_pkg::OFF_STATUS, 32'h0000_0200);
    wr(nfc_pkg::OFF_CTRL, 32'h0000_0002);
    wait_n(3);
    chk("fault left", 32'(fault_act), 32'h0000_0000);
    $display("test timeout done");
  endtask
  // safe mode: pad disable and critical report even with every input disabled
  task automatic t_safe();
    wr(nfc_pkg::OFF_ENABLE, 32'h0000_0000);
    wr(nfc_pkg::OFF_CTRL, 32'h0000_0001);
    safe <= 1'b1;
    wait_n(3);
    chk("pad hiz", 32'(pad_hiz), 32'h0000_0001);
    chk("pins healthy", 32'(err_out), 32'(nfc_pkg::ERR_OK));
    crit <= 1'b1;
    wait_n(3);
    chk("critical report", 32'(err_out), 32'(nfc_pkg::ERR_FAULT));
    crit <= 1'b0;
    safe <= 1'b0;
    wait_n(3);
    chk("pad released", 32'(pad_hiz), 32'h0000_0000);
    wr(nfc_pkg::OFF_ENABLE, nfc_pkg::IMPL_MASK);
    $display("test safe done");
  endtask
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    {hresetn, hsel, hwrite, crit, safe} = 5'b00000;
    mon_rst_n = 1'b0;
    {haddr, hwdata, src} = {32'h0, 32'h0, 32'h0};
    htrans = 2'b00;
    hsize = 3'b010;
    wait_n(20);
    chk("pins float in reset", 32'(err_oe), 32'h0000_0000);
    hresetn <= 1'b1;
    mon_rst_n <= 1'b1;
    t_regs();
    t_map();
    t_react(0);
    t_react(8);
    t_react(12);
    t_react(20);
    t_react(21);
    t_react(25);
    t_timeout();
    t_safe();
    hresetn <= 1'b0;
    wait_n(2);
    chk("pins float mid reset", 32'(err_oe), 32'h0000_0000);
    hresetn <= 1'b1;
    wait_n(2);
    chk("pins driven again", 32'(err_oe), 32'h0000_0003);
    test_done();
  end
endmodule
